// file: hw/irpwm_top.sv
// IR carrier PWM modulator: APB registers, carrier and data generators, output stage
`timescale 1ns/10ps
// Function
// - Transmit output is carrier AND data signal.
// - Carrier comes from an 8-bit counter compared with duty and period.
// - Carrier frequency is clock over period+1, duty is (duty+1)/(period+1).
// - Carrier counter cleared by counter reset, runs with data counter.
// - Carrier toggles when its counter equals the duty value.
// - Carrier toggles and counter returns to zero at period match.
// - Data signal comes from a readable 16-bit counter and two compares.
// - Symbol lasts cycle+1 clocks, duty is (high+1)/(cycle+1).
// - Data counter cleared by counter reset, started/stopped by run.
// - Data signal toggles at high-length compare match.
// - Data signal toggles and counter returns to zero at cycle match.
// - Separate flags for high-length match and cycle match.
// - Repeat mode keeps counting until run is cleared.
// - One-shot mode stops run at the first cycle match.
// - Shadow disabled: compares use the registers directly.
// - Shadow enabled: compares use shadow copies of high and cycle.
// - Shadow copies load at cycle match of the buffered value.
// - Pending flag sets on write with shadow enabled, clears when the value is loaded.
// - Match flags clear by writing 1 or by block soft reset.
// - Interrupt request only while a flag and its enable are set.
// - Counter reset reads 1 while busy, self-clears or clears on soft reset.
// - While running, clear pulse is high for cycle minus high clocks.
module irpwm_top
    import irpwm_pkg::*;
#(
    parameter int CW = 8,
    parameter int DW = 16
) (
    input wire logic i_sys_clk, // System clock, 125 MHz
    input wire logic i_rst, // Asynchronous reset, active high
    input wire logic i_psel, // APB select
    input wire logic i_penable, // APB enable
    input wire logic i_pwrite, // APB direction, high for write
    input wire logic [7:0] i_paddr, // APB byte address
    input wire logic [31:0] i_pwdata, // APB write data
    output logic [31:0] o_prdata, // APB read data
    output logic o_pready, // APB ready
    output logic o_pslverr, // APB error on unmapped address
    output logic o_ir_tx_out, // Modulated transmit output
    output logic o_clear_pulse_out, // Clear pulse output
    output logic o_irq // Interrupt request, active high
);
    // Control and data registers
    logic [CW-1:0] carrier_duty;
    logic [CW-1:0] carrier_period;
    logic [DW-1:0] high_length;
    logic [DW-1:0] symbol_cycle;
    logic [DW-1:0] high_buf;
    logic [DW-1:0] cycle_buf;
    logic count_clock_enable;
    logic oneshot_select;
    logic shadow_enable;
    logic out_invert;
    logic count_run;
    logic counter_reset;
    logic carrier_mod_enable;
    logic high_match_flag;
    logic cycle_match_flag;
    logic high_len_pending;
    logic cycle_len_pending;
    logic [1:0] irq_enable;

    irpwm_wave_if #(.W(CW)) carr_if ();
    irpwm_wave_if #(.W(DW)) data_if ();

    // Bus phase decode
    wire setup = i_psel && !i_penable;
    wire wr_en = i_psel && i_penable && o_pready && i_pwrite;
    wire wr_carr = wr_en && (i_paddr == ADDR_CARRIER);
    wire wr_high = wr_en && (i_paddr == ADDR_HIGH_LEN);
    wire wr_cycle = wr_en && (i_paddr == ADDR_SYM_CYCLE);
    wire wr_ctrl = wr_en && (i_paddr == ADDR_CTRL);
    wire wr_flag = wr_en && (i_paddr == ADDR_IRQ_FLAG);
    wire wr_irqen = wr_en && (i_paddr == ADDR_IRQ_EN);
    wire wr_cctl = wr_en && (i_paddr == ADDR_CARR_CTRL);
    wire addr_hit = (i_paddr[1:0] == 2'h0) && (i_paddr <= ADDR_CARR_CTRL);
    wire soft_rst = wr_ctrl && i_pwdata[CTRL_SOFT_RST];

    // Counting state and match events
    wire running = count_run && count_clock_enable;
    wire tick = running && !counter_reset;
    wire high_hit = data_if.hit_a;
    wire cyc_hit = data_if.hit_b;
    // Shadow copies track the registers whenever no symbol is in flight
    wire load = !shadow_enable || !running || cyc_hit || counter_reset;

    // Both generators share one tick so carrier and data stay in step
    assign carr_if.tick = tick;
    assign carr_if.clear = counter_reset;
    assign carr_if.cmp_a = carrier_duty;
    assign carr_if.cmp_b = carrier_period;
    assign data_if.tick = tick;
    assign data_if.clear = counter_reset;
    assign data_if.cmp_a = shadow_enable ? high_buf : high_length;
    assign data_if.cmp_b = shadow_enable ? cycle_buf : symbol_cycle;

    irpwm_wave #(.W(CW)) u_carrier (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .wv(carr_if)
    );

    irpwm_wave #(.W(DW)) u_data (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .wv(data_if)
    );

    // Output forming; idle leaves the line at its inactive level
    wire carr_eff = carr_if.level || !carrier_mod_enable;
    wire next_tx = out_invert ^ (running && carr_eff && data_if.level);
    wire next_clr = running && !data_if.level;
    wire [1:0] flags = {cycle_match_flag, high_match_flag};
    wire next_irq = |(flags & irq_enable);

    // Read multiplexer; reserved bits read as zero
    wire [31:0] rd_ctrl = {22'h0, counter_reset, count_run, 3'h0, out_invert, shadow_enable,
                           oneshot_select, 1'b0, count_clock_enable};
    wire [31:0] rd_flag = {27'h0, running, cycle_len_pending, high_len_pending, flags};
    wire [31:0] rd_data = (i_paddr == ADDR_CARRIER) ? {16'h0, carrier_period, carrier_duty} :
                          (i_paddr == ADDR_HIGH_LEN) ? {16'h0, high_length} :
                          (i_paddr == ADDR_SYM_CYCLE) ? {16'h0, symbol_cycle} :
                          (i_paddr == ADDR_CTRL) ? rd_ctrl :
                          (i_paddr == ADDR_SYM_COUNT) ? {16'h0, data_if.count} :
                          (i_paddr == ADDR_IRQ_FLAG) ? rd_flag :
                          (i_paddr == ADDR_IRQ_EN) ? {30'h0, irq_enable} :
                          (i_paddr == ADDR_CARR_CTRL) ? {31'h0, carrier_mod_enable} : RD_ZERO;

    // Bus answer: ready one cycle after setup, data and error captured with it
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= RD_ZERO;
        end else begin
            o_pready <= setup;
            o_pslverr <= setup && !addr_hit;
            o_prdata <= (setup && !i_pwrite && addr_hit) ? rd_data : RD_ZERO;
        end
    end

    // Compare value registers; software may rewrite them mid-symbol
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            carrier_duty <= RST_CARR_DUTY;
            carrier_period <= RST_CARR_PER;
            high_length <= RST_HIGH_LEN;
            symbol_cycle <= RST_SYM_CYCLE;
        end else begin
            if (wr_carr) begin
                carrier_duty <= i_pwdata[CARR_DUTY_LSB +: CW];
                carrier_period <= i_pwdata[CARR_PER_LSB +: CW];
            end
            if (wr_high) begin
                high_length <= i_pwdata[DW-1:0];
            end
            if (wr_cycle) begin
                symbol_cycle <= i_pwdata[DW-1:0];
            end
        end
    end

    // Mode bits; soft reset returns the control bits to defaults, carrier and interrupt enables keep their values
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            count_clock_enable <= 1'b0;
            oneshot_select <= 1'b0;
            shadow_enable <= 1'b0;
            out_invert <= 1'b0;
            carrier_mod_enable <= 1'b0;
            irq_enable <= 2'h0;
        end else if (soft_rst) begin
            count_clock_enable <= 1'b0;
            oneshot_select <= 1'b0;
            shadow_enable <= 1'b0;
            out_invert <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                count_clock_enable <= i_pwdata[CTRL_CLK_EN];
                oneshot_select <= i_pwdata[CTRL_ONESHOT];
                shadow_enable <= i_pwdata[CTRL_SHADOW];
                out_invert <= i_pwdata[CTRL_INVERT];
            end
            if (wr_cctl) begin
                carrier_mod_enable <= i_pwdata[CCTL_MOD_EN];
            end
            if (wr_irqen) begin
                irq_enable <= i_pwdata[FLAG_CYCLE:FLAG_HIGH];
            end
        end
    end

    // Run control: software write wins, one-shot stops at symbol end
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            count_run <= 1'b0;
        end else if (soft_rst) begin
            count_run <= 1'b0;
        end else if (wr_ctrl) begin
            count_run <= i_pwdata[CTRL_RUN];
        end else if (oneshot_select && cyc_hit) begin
            count_run <= 1'b0;
        end
    end

    // Counter reset lasts one cycle; needs the count clock enabled
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            counter_reset <= 1'b0;
        end else if (soft_rst) begin
            counter_reset <= 1'b0;
        end else begin
            counter_reset <= wr_ctrl && i_pwdata[CTRL_PRESET] && (i_pwdata[CTRL_CLK_EN] || count_clock_enable);
        end
    end

    // Shadow buffers; a write in the load cycle stays pending for next time
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            high_buf <= RST_HIGH_LEN;
            cycle_buf <= RST_SYM_CYCLE;
        end else if (load) begin
            high_buf <= high_length;
            cycle_buf <= symbol_cycle;
        end
    end

    // Pending flags: set on write wins over the load that clears them
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            high_len_pending <= 1'b0;
            cycle_len_pending <= 1'b0;
        end else if (soft_rst) begin
            high_len_pending <= 1'b0;
            cycle_len_pending <= 1'b0;
        end else begin
            high_len_pending <= (wr_high && shadow_enable) || (high_len_pending && !load);
            cycle_len_pending <= (wr_cycle && shadow_enable) || (cycle_len_pending && !load);
        end
    end

    // Match flags: hardware set wins over a write-one clear
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            high_match_flag <= 1'b0;
            cycle_match_flag <= 1'b0;
        end else if (soft_rst) begin
            high_match_flag <= 1'b0;
            cycle_match_flag <= 1'b0;
        end else begin
            high_match_flag <= high_hit || (high_match_flag && !(wr_flag && i_pwdata[FLAG_HIGH]));
            cycle_match_flag <= cyc_hit || (cycle_match_flag && !(wr_flag && i_pwdata[FLAG_CYCLE]));
        end
    end

    // Registered pins so they never glitch
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_ir_tx_out <= 1'b0;
            o_clear_pulse_out <= 1'b0;
            o_irq <= 1'b0;
        end else begin
            o_ir_tx_out <= next_tx;
            o_clear_pulse_out <= next_clr;
            o_irq <= next_irq;
        end
    end

    // Checks on the generator and control behaviour
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    sequence s_symbol_end;
        tick && cyc_hit;
    endsequence

    sequence s_wrap_toggled;
        (data_if.count == '0) && (data_if.level != $past(data_if.level));
    endsequence

    a_out_and_gate: assert property (
        ##1 (o_ir_tx_out == ($past(out_invert) ^ ($past(running) && $past(data_if.level)
            && ($past(carr_if.level) || !$past(carrier_mod_enable))))))
        else $error("transmit output is not carrier and data");

    a_carrier_wrap: assert property (
        (tick && carr_if.count == carrier_period) |=> (carr_if.count == '0 && carr_if.level != $past(carr_if.level)))
        else $error("carrier did not wrap and toggle at period");

    a_carrier_duty_flip: assert property (
        (tick && carr_if.count == carrier_duty && carrier_duty != carrier_period)
            |=> (carr_if.level != $past(carr_if.level)))
        else $error("carrier did not toggle at duty");

    a_symbol_wrap: assert property (
        s_symbol_end |=> s_wrap_toggled)
        else $error("data counter did not wrap and toggle at cycle");

    a_count_hold: assert property (
        (!tick && !counter_reset) |=> $stable(data_if.count))
        else $error("data counter moved while stopped");

    a_high_flag_set: assert property (
        (high_hit && !soft_rst) |=> high_match_flag)
        else $error("high match flag not set");

    a_oneshot_stop: assert property (
        (s_symbol_end and (oneshot_select && !wr_ctrl)) |=> !count_run [*2])
        else $error("one-shot did not stop");

    a_shadow_load: assert property (
        (shadow_enable && cyc_hit) |=> (high_buf == $past(high_length) && cycle_buf == $past(symbol_cycle)))
        else $error("shadow buffers not loaded at symbol end");

    a_pending_set: assert property (
        (wr_cycle && shadow_enable && !soft_rst) |=> cycle_len_pending)
        else $error("cycle pending not set on write");

    a_irq_gate: assert property (
        ##1 (o_irq == $past(|(flags & irq_enable))))
        else $error("interrupt request does not follow enabled flags");

    a_reset_one_cycle: assert property (
        counter_reset |=> (!counter_reset && data_if.count == '0 && carr_if.count == '0))
        else $error("counter reset not one cycle or counters not cleared");

    // High match alone must flip the data level; a cycle match there would cancel it
    a_data_high_flip: assert property (
        (high_hit && !cyc_hit) |=> (data_if.level != $past(data_if.level)))
        else $error("data signal did not toggle at high match");

    a_cycle_flag_set: assert property (
        (cyc_hit && !soft_rst) |=> cycle_match_flag)
        else $error("cycle match flag not set");

    // A load with no fresh write must release the pending flag
    a_pending_clear: assert property (
        (cycle_len_pending && load && !wr_cycle) |=> !cycle_len_pending)
        else $error("cycle pending not cleared after shadow load");
endmodule

// file: hw/irpwm_pkg.sv
// Package: register map, field positions and reset values of the IR carrier modulator
package irpwm_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_CARRIER = 8'h00;
    localparam logic [7:0] ADDR_HIGH_LEN = 8'h04;
    localparam logic [7:0] ADDR_SYM_CYCLE = 8'h08;
    localparam logic [7:0] ADDR_CTRL = 8'h0c;
    localparam logic [7:0] ADDR_SYM_COUNT = 8'h10;
    localparam logic [7:0] ADDR_IRQ_FLAG = 8'h14;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h18;
    localparam logic [7:0] ADDR_CARR_CTRL = 8'h1c;
    // Carrier register fields
    localparam int CARR_DUTY_LSB = 0;
    localparam int CARR_PER_LSB = 8;
    // Counter control fields
    localparam int CTRL_CLK_EN = 0;
    localparam int CTRL_SOFT_RST = 1;
    localparam int CTRL_ONESHOT = 2;
    localparam int CTRL_SHADOW = 3;
    localparam int CTRL_INVERT = 4;
    localparam int CTRL_RUN = 8;
    localparam int CTRL_PRESET = 9;
    // Flag register fields
    localparam int FLAG_HIGH = 0;
    localparam int FLAG_CYCLE = 1;
    localparam int FLAG_HIGH_PEND = 2;
    localparam int FLAG_CYCLE_PEND = 3;
    localparam int FLAG_RUNNING = 4;
    // Carrier control fields
    localparam int CCTL_MOD_EN = 0;
    // Reset values
    localparam logic [7:0] RST_CARR_DUTY = 8'h00;
    localparam logic [7:0] RST_CARR_PER = 8'h01;
    localparam logic [15:0] RST_HIGH_LEN = 16'h0000;
    localparam logic [15:0] RST_SYM_CYCLE = 16'h0001;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;
endpackage

// file: hw/irpwm_wave_if.sv
// Interface: one compare-and-toggle counter seen from the controlling block
`timescale 1ns/10ps
interface irpwm_wave_if #(parameter int W = 8);
    logic tick;
    logic clear;
    logic [W-1:0] cmp_a;
    logic [W-1:0] cmp_b;
    logic [W-1:0] count;
    logic level;
    logic hit_a;
    logic hit_b;
    modport core (input tick, input clear, input cmp_a, input cmp_b,
                  output count, output level, output hit_a, output hit_b);
    modport ctrl (output tick, output clear, output cmp_a, output cmp_b,
                  input count, input level, input hit_a, input hit_b);
endinterface

// file: hw/irpwm_wave.sv
// Compare-and-toggle counter shared by the carrier and data generators
`timescale 1ns/10ps
module irpwm_wave #(
    parameter int W = 8
) (
    input wire logic i_sys_clk, // System clock
    input wire logic i_rst, // Asynchronous reset, active high
    irpwm_wave_if.core wv // Counter controls and results
);
    // Match strobes only while counting
    assign wv.hit_a = wv.tick && (wv.count == wv.cmp_a);
    assign wv.hit_b = wv.tick && (wv.count == wv.cmp_b);

    // Count up, wrap at the period match; level starts high after a clear
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            wv.count <= '0;
            wv.level <= 1'b1;
        end else if (wv.clear) begin
            wv.count <= '0;
            wv.level <= 1'b1;
        end else if (wv.tick) begin
            wv.count <= wv.hit_b ? '0 : wv.count + 1'b1;
            wv.level <= wv.level ^ (wv.hit_a ^ wv.hit_b);
        end
    end
endmodule

// file: test/irpwm_led_model.sv
// Far-side model: infrared emitter input that logs run lengths of one line
`timescale 1ns/10ps
module irpwm_led_model (
    input wire logic i_sys_clk, // System clock
    input wire logic i_arm, // Low flushes the logs
    input wire logic i_line // Line driving the emitter
);
    int high_q[$];
    int low_q[$];
    int run_len = 1;
    logic prev = 1'b0;
    logic seen = 1'b0;

    // Only runs bounded by two edges are logged, so idle time never counts
    always @(posedge i_sys_clk) begin
        if (!i_arm) begin
            high_q.delete();
            low_q.delete();
            seen <= 1'b0;
            run_len <= 1;
            prev <= i_line;
        end else if (i_line !== prev) begin
            if (seen && prev)
                high_q.push_back(run_len);
            else if (seen)
                low_q.push_back(run_len);
            seen <= 1'b1;
            run_len <= 1;
            prev <= i_line;
        end else begin
            run_len <= run_len + 1;
        end
    end
endmodule

// file: test/irpwm_top_tb.sv
// Self-checking bench for the IR carrier PWM modulator
`timescale 1ns/10ps
module irpwm_top_tb import irpwm_pkg::*; ();
    localparam logic [31:0] EN = 32'h1 << CTRL_CLK_EN;
    localparam logic [31:0] SRST = 32'h1 << CTRL_SOFT_RST;
    localparam logic [31:0] OS = 32'h1 << CTRL_ONESHOT;
    localparam logic [31:0] SH = 32'h1 << CTRL_SHADOW;
    localparam logic [31:0] INV = 32'h1 << CTRL_INVERT;
    localparam logic [31:0] RUN = 32'h1 << CTRL_RUN;
    localparam logic [31:0] PRE = 32'h1 << CTRL_PRESET;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic arm = 1'b0;
    wire logic [31:0] prdata;
    wire logic pready;
    wire logic pslverr;
    wire logic tx;
    wire logic clr;
    wire logic irq;
    int err_total = 0;
    int cmp_count = 0;
    logic [31:0] seed = 32'd78599;

    irpwm_top #(.CW(8), .DW(16)) i_irpwm_top (
        .i_sys_clk(sys_clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .o_ir_tx_out(tx),
        .o_clear_pulse_out(clr), .o_irq(irq));
    irpwm_led_model i_led_tx (.i_sys_clk(sys_clk), .i_arm(arm), .i_line(tx));
    irpwm_led_model i_led_clr (.i_sys_clk(sys_clk), .i_arm(arm), .i_line(clr));

    // 125 MHz clock
    always #4 sys_clk = ~sys_clk;

    // Xorshift source, fixed seed for repeatable runs
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // APB master; waits on pready with no assumed latency, watchdog ends a hang
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        check(nm, r, exp);
    endtask

    // Preset first, then run, as the counters expect
    task automatic start(input logic [31:0] m);
        wr(ADDR_CTRL, EN | m | PRE);
        wr(ADDR_CTRL, EN | m | RUN);
    endtask

    task automatic flush();
        @(posedge sys_clk) arm <= 1'b0;
        @(posedge sys_clk) arm <= 1'b1;
    endtask

    // Registered pins settle one edge after the write edge
    task automatic settle();
        repeat (2) @(negedge sys_clk);
    endtask

    task automatic done(input string nm);
        $display("test %s finished, mismatches so far %0d", nm, err_total);
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Watchdog, far beyond the several hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        $display("[ERR] watchdog expected finish seen timeout");
        finish_test();
    end

    initial begin
        int h;
        int c;
        int p;
        int d;
        int i;
        int k;
        int n;
        time t0;
        logic [31:0] r;
        logic e;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        // Reset values and an unmapped access
        rdchk("carrier rst", ADDR_CARRIER, {16'h0, RST_CARR_PER, RST_CARR_DUTY});
        rdchk("high rst", ADDR_HIGH_LEN, {16'h0, RST_HIGH_LEN});
        rdchk("cycle rst", ADDR_SYM_CYCLE, {16'h0, RST_SYM_CYCLE});
        rdchk("ctrl rst", ADDR_CTRL, RD_ZERO);
        rdchk("count rst", ADDR_SYM_COUNT, RD_ZERO);
        apb(1'b0, 8'h20, 32'h0, r, e);
        check("unmapped err", 32'(e), 32'h1);
        check("unmapped data", r, RD_ZERO);
        done("reset");
        // Carrier inside a long data high phase, random period and duty
        wr(ADDR_CARR_CTRL, 32'h1);
        p = 2 + int'(rnd() % 32'd30);
        d = int'(rnd() % 32'(p));
        wr(ADDR_CARRIER, 32'((p << 8) | d));
        wr(ADDR_HIGH_LEN, 32'd200);
        wr(ADDR_SYM_CYCLE, 32'd201);
        flush();
        start(32'h0);
        rdchk("preset self clear", ADDR_CTRL, EN | RUN);
        repeat (4 * (p + 1) + 4) @(posedge sys_clk);
        wr(ADDR_CTRL, EN);
        check("carrier high", 32'(i_led_tx.high_q[0]), 32'(d + 1));
        check("carrier low", 32'(i_led_tx.low_q[0]), 32'(p - d));
        check("carrier high 2", 32'(i_led_tx.high_q[1]), 32'(d + 1));
        wr(ADDR_CARR_CTRL, 32'h0);
        done("carrier");
        // Data symbols with carrier forced high, repeat mode, flags and irq
        for (i = 0; i < 3; i++) begin
            h = int'(rnd() % 32'd20);
            c = h + 1 + int'(rnd() % 32'd20);
            wr(ADDR_HIGH_LEN, 32'(h));
            wr(ADDR_SYM_CYCLE, 32'(c));
            flush();
            start(32'h0);
            t0 = $time;
            repeat (3 * (c + 1) + 6) @(posedge sys_clk);
            rdchk("flags running", ADDR_IRQ_FLAG, 32'h13);
            wr(ADDR_CTRL, EN);
            // One tick per 8 ns clock from the run edge to the stop edge, wrapping after cycle+1
            n = int'(($time - t0) / 64'd8) % (c + 1);
            check("data high", 32'(i_led_tx.high_q[0]), 32'(h + 1));
            check("data low", 32'(i_led_tx.low_q[0]), 32'(c - h));
            check("data high 2", 32'(i_led_tx.high_q[1]), 32'(h + 1));
            check("clear pulse", 32'(i_led_clr.high_q[0]), 32'(c - h));
            rdchk("count at stop", ADDR_SYM_COUNT, 32'(n));
            rdchk("count held", ADDR_SYM_COUNT, 32'(n));
            wr(ADDR_IRQ_EN, 32'h0);
            settle();
            check("irq masked", 32'(irq), 32'h0);
            wr(ADDR_IRQ_EN, 32'h3);
            settle();
            check("irq on", 32'(irq), 32'h1);
            wr(ADDR_IRQ_FLAG, 32'h3);
            rdchk("flags w1c", ADDR_IRQ_FLAG, 32'h0);
            settle();
            check("irq off", 32'(irq), 32'h0);
        end
        done("data");
        // Shadow compares: next symbol written during the current one
        wr(ADDR_HIGH_LEN, 32'd4);
        wr(ADDR_SYM_CYCLE, 32'd30);
        flush();
        start(SH);
        wr(ADDR_HIGH_LEN, 32'd9);
        wr(ADDR_SYM_CYCLE, 32'd20);
        apb(1'b0, ADDR_IRQ_FLAG, 32'h0, r, e);
        check("pending set", r & 32'h1c, 32'h1c);
        repeat (90) @(posedge sys_clk);
        wr(ADDR_CTRL, EN);
        check("old high", 32'(i_led_tx.high_q[0]), 32'd5);
        check("old low", 32'(i_led_tx.low_q[0]), 32'd26);
        check("new high", 32'(i_led_tx.high_q[1]), 32'd10);
        check("new low", 32'(i_led_tx.low_q[1]), 32'd11);
        apb(1'b0, ADDR_IRQ_FLAG, 32'h0, r, e);
        check("pending clear", r & 32'hc, 32'h0);
        wr(ADDR_IRQ_FLAG, 32'h3);
        done("shadow");
        // One-shot stops itself after one symbol
        wr(ADDR_HIGH_LEN, 32'd3);
        wr(ADDR_SYM_CYCLE, 32'd7);
        flush();
        start(OS);
        k = 0;
        do begin
            apb(1'b0, ADDR_IRQ_FLAG, 32'h0, r, e);
            k++;
        end while (r[FLAG_RUNNING] !== 1'b0 && k < 60);
        check("oneshot flags", r, 32'h3);
        settle();
        check("oneshot runs", 32'(i_led_tx.high_q.size()), 32'h1);
        check("oneshot high", 32'(i_led_tx.high_q[0]), 32'd4);
        done("oneshot");
        // Inversion, then soft reset clears control and flags
        wr(ADDR_CTRL, EN | INV);
        settle();
        check("tx inverted", 32'(tx), 32'h1);
        wr(ADDR_CTRL, SRST);
        rdchk("ctrl soft rst", ADDR_CTRL, RD_ZERO);
        rdchk("flags soft rst", ADDR_IRQ_FLAG, RD_ZERO);
        settle();
        check("tx plain", 32'(tx), 32'h0);
        done("soft reset");
        finish_test();
    end
endmodule
